// ==== rtl/csm_decoder.sv ====
`timescale 1ns/1ns
// Purpose: Chip-select generation, internal decode and reset vector.
// Assumes: Address and strobe come from logic on i_clock.
// Notes:   All outputs are registered, so selects lag the address by one clock.
module csm_decoder (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_vector_prefix_bit,
   input  wire logic        i_internal_nvm_enable,
   input  wire logic        i_bus_valid,
   input  wire logic [31:0] i_bus_addr,
   input  wire logic        i_wr_en,
   input  wire logic [1:0]  i_wr_region,
   input  wire logic        i_wr_option,
   input  wire logic [31:0] i_wr_data,
   output logic      [3:0]  o_cs_n,
   output logic             o_boot_mode,
   output logic             o_nvm_sel,
   output logic      [3:0]  o_nvm_block,
   output logic             o_nvm_ctrl_sel,
   output logic             o_pbi_sel,
   output logic      [31:0] o_reset_vector
);
   //--------------------------------------------------
   // Strap synchroniser
   //--------------------------------------------------
   // Left out of reset so the strap stands settled when reset lets go
   logic strap_meta_reg;
   logic strap_sync_reg;

   always_ff @(posedge i_clock) begin
      strap_meta_reg <= i_vector_prefix_bit;
      strap_sync_reg <= strap_meta_reg;
   end

   //--------------------------------------------------
   // Region registers
   //--------------------------------------------------
   logic [3:0][31:0] base_reg, base_next;
   logic [3:0][31:0] option_reg, option_next;
   logic             boot_reg, boot_next;
   logic             vec_cap_reg, vec_cap_next;
   logic [31:0]      vector_reg, vector_next;

   always_comb begin
      base_next    = base_reg;
      option_next  = option_reg;
      boot_next    = boot_reg;
      vec_cap_next = 1'b1;
      vector_next  = vector_reg;
      if (i_wr_en) begin
         if (i_wr_option) begin
            option_next[i_wr_region] = i_wr_data;
         end else begin
            base_next[i_wr_region] = i_wr_data;
         end
         // Writing option zero ends the global select
         if (i_wr_option && i_wr_region == csm_pkg::REGION_BOOT) begin
            boot_next = 1'b0;
         end
      end
      // Strap is caught once, on the first clock after release
      if (!vec_cap_reg) begin
         vector_next = strap_sync_reg ? csm_pkg::VEC_HIGH : csm_pkg::VEC_LOW;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         base_reg    <= {csm_pkg::NUM_REGIONS{csm_pkg::REG_RESET}};
         option_reg  <= {csm_pkg::NUM_REGIONS{csm_pkg::REG_RESET}};
         boot_reg    <= 1'b1;
         vec_cap_reg <= 1'b0;
         vector_reg  <= csm_pkg::VEC_LOW;
      end else begin
         base_reg    <= base_next;
         option_reg  <= option_next;
         boot_reg    <= boot_next;
         vec_cap_reg <= vec_cap_next;
         vector_reg  <= vector_next;
      end
   end

   //--------------------------------------------------
   // Region compare
   //--------------------------------------------------
   csm_match_if m ();
   assign m.addr   = i_bus_addr;
   assign m.base   = base_reg;
   assign m.option = option_reg;
   csm_region_cmp u_cmp (
      .m (m)
   );

   //--------------------------------------------------
   // Select outputs
   //--------------------------------------------------
   logic [3:0]  cs_n_reg, cs_n_next;
   logic        nvm_reg, nvm_next;
   logic [3:0]  blk_reg, blk_next;
   logic        nvm_ctrl_reg, nvm_ctrl_next;
   logic        pbi_reg, pbi_next;
   logic        in_nvm, in_ctrl, in_pbi;

   always_comb begin
      // Offset form, so a base of zero is no always-true compare
      in_nvm  = (i_bus_addr - csm_pkg::NVM_BASE) <= (csm_pkg::NVM_LAST - csm_pkg::NVM_BASE);
      in_ctrl = i_bus_addr >= csm_pkg::NVM_CTRL_BASE && i_bus_addr <= csm_pkg::NVM_CTRL_LAST;
      in_pbi  = i_bus_addr >= csm_pkg::PBI_BASE && i_bus_addr <= csm_pkg::PBI_LAST;
      cs_n_next = 4'hF;
      if (i_bus_valid) begin
         if (boot_reg) begin
            // Only select zero drives while booting, others stay quiet
            cs_n_next[csm_pkg::REGION_BOOT] = 1'b0;
         end else begin
            cs_n_next = ~m.hit;
         end
      end
      // Disabled NVM looks absent, array and controls alike
      nvm_next      = i_bus_valid && in_nvm && i_internal_nvm_enable;
      nvm_ctrl_next = i_bus_valid && in_ctrl && i_internal_nvm_enable;
      // Sixteen 64-kilobyte blocks
      blk_next      = i_bus_addr[csm_pkg::NVM_BLOCK_LSB +: csm_pkg::NVM_BLOCK_W];
      pbi_next      = i_bus_valid && in_pbi;
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         cs_n_reg     <= 4'hF;
         nvm_reg      <= 1'b0;
         blk_reg      <= 4'h0;
         nvm_ctrl_reg <= 1'b0;
         pbi_reg      <= 1'b0;
      end else begin
         cs_n_reg     <= cs_n_next;
         nvm_reg      <= nvm_next;
         blk_reg      <= blk_next;
         nvm_ctrl_reg <= nvm_ctrl_next;
         pbi_reg      <= pbi_next;
      end
   end

   assign o_cs_n         = cs_n_reg;
   assign o_boot_mode    = boot_reg;
   assign o_nvm_sel      = nvm_reg;
   assign o_nvm_block    = blk_reg;
   assign o_nvm_ctrl_sel = nvm_ctrl_reg;
   assign o_pbi_sel      = pbi_reg;
   assign o_reset_vector = vector_reg;
endmodule // csm_decoder

// ==== rtl/csm_match_if.sv ====
`timescale 1ns/1ns
// Purpose: Carries the address and per-region compare results.
// Assumes: One instance between the top and the region comparator.
// Notes:   Bases and options are packed four words wide.
interface csm_match_if;
   logic [csm_pkg::ADDR_W-1:0]                         addr;
   logic [csm_pkg::NUM_REGIONS-1:0][csm_pkg::ADDR_W-1:0] base;
   logic [csm_pkg::NUM_REGIONS-1:0][csm_pkg::ADDR_W-1:0] option;
   logic [csm_pkg::NUM_REGIONS-1:0]                    hit;
   modport top (output addr, output base, output option, input hit);
   modport cmp (input addr, input base, input option, output hit);
endinterface

// ==== rtl/csm_pkg.sv ====
// Purpose: Constants for the chip-select and memory map decoder.
// Assumes: 32-bit system bus address, one clock, synchronous reset.
// Notes:   Base/option layout: base[31:15] address, option[31:15] mask.
//
// Behaviour
// - Four programmable regions, four active-low selects.
// - Select zero answers everything until option zero written.
// - Reset vector low or high by prefix bit.
// - NVM enable low hides array and controls.
// - Internal NVM is sixteen 64-kilobyte blocks.
// - Peripheral bus window 0x0030_0000 to 0x0030_7FFF.
package csm_pkg;
   localparam int          NUM_REGIONS   = 4;
   localparam int          ADDR_W        = 32;
   localparam int          MATCH_LSB     = 15;
   localparam int          VALID_BIT     = 0;
   localparam int          NVM_BLOCKS    = 16;
   localparam int          NVM_BLOCK_LSB = 16;
   localparam int          NVM_BLOCK_W   = 4;
   localparam logic [31:0] NVM_BASE      = 32'h0000_0000;
   localparam logic [31:0] NVM_LAST      = 32'h000F_FFFF;
   localparam logic [31:0] NVM_CTRL_BASE = 32'h002F_C000;
   localparam logic [31:0] NVM_CTRL_LAST = 32'h002F_FFFF;
   localparam logic [31:0] PBI_BASE      = 32'h0030_0000;
   localparam logic [31:0] PBI_LAST      = 32'h0030_7FFF;
   localparam logic [31:0] VEC_LOW       = 32'h0000_0100;
   localparam logic [31:0] VEC_HIGH      = 32'hFFF0_0100;
   localparam logic [31:0] REG_RESET     = 32'h0000_0000;
   localparam logic [1:0]  REGION_BOOT   = 2'h0;
endpackage

// ==== rtl/csm_region_cmp.sv ====
`timescale 1ns/1ns
// Purpose: Compares the bus address with every programmed region.
// Assumes: Purely combinational; the top registers the result.
// Notes:   A region without its valid bit never hits.
module csm_region_cmp (
   csm_match_if.cmp m
);
   //--------------------------------------------------
   // Region compare
   //--------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < csm_pkg::NUM_REGIONS; g++) begin : g_region
         logic [csm_pkg::ADDR_W-1:csm_pkg::MATCH_LSB] mask;
         assign mask = m.option[g][csm_pkg::ADDR_W-1:csm_pkg::MATCH_LSB];
         // Masked address equals masked base
         assign m.hit[g] = m.base[g][csm_pkg::VALID_BIT]
            && (((m.addr[csm_pkg::ADDR_W-1:csm_pkg::MATCH_LSB]
                  ^ m.base[g][csm_pkg::ADDR_W-1:csm_pkg::MATCH_LSB]) & mask) == '0);
      end
   endgenerate
endmodule // csm_region_cmp

// ==== test/csm_bank_model.sv ====
`timescale 1ns/1ns
// Purpose: External banks behind the four chip selects.
// Assumes: One bank per select, zero-wait banks.
// Notes:   Each selected cycle is one beat.
module csm_bank_model (
   input  wire logic       i_clock,
   input  wire logic [3:0] i_cs_n,
   output logic      [3:0] o_ack_n
);
   // Lone bank per select one ack per beat
   always_ff @(posedge i_clock) begin
      o_ack_n <= i_cs_n;
   end
endmodule // csm_bank_model

// ==== test/csm_decoder_asserts.sv ====
`timescale 1ns/1ns
// Purpose: Port checks of the decoder.
// Assumes: One clock domain.
// Notes:   Selects lag the address by one clock.
module csm_decoder_chk (
   input wire logic        i_clock, i_rst, i_vector_prefix_bit, i_internal_nvm_enable,
   input wire logic        i_bus_valid, i_wr_en, i_wr_option,
   input wire logic [31:0] i_bus_addr, i_wr_data, o_reset_vector,
   input wire logic [1:0]  i_wr_region,
   input wire logic [3:0]  o_cs_n, o_nvm_block,
   input wire logic        o_boot_mode, o_nvm_sel, o_nvm_ctrl_sel, o_pbi_sel
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence s_opt0_wr; i_wr_en && i_wr_option && i_wr_region == 2'h0; endsequence
   sequence s_release; $fell(i_rst); endsequence
   boot_all_a: assert property (o_boot_mode && i_bus_valid |=> o_cs_n == 4'hE)
      else $error("boot select missed");
   boot_end_a: assert property (s_opt0_wr |=> !o_boot_mode)
      else $error("boot not ended");
   boot_hold_a: assert property (o_boot_mode && !(i_wr_en && i_wr_option) |=> o_boot_mode)
      else $error("boot ended early");
   idle_cs_a: assert property (!i_bus_valid |=> o_cs_n == 4'hF)
      else $error("select without access");
   nvm_off_a: assert property (!i_internal_nvm_enable |=> !o_nvm_sel && !o_nvm_ctrl_sel)
      else $error("nvm seen while off");
   pbi_win_a: assert property (i_bus_valid |=> o_pbi_sel == ($past(i_bus_addr) >=
      csm_pkg::PBI_BASE && $past(i_bus_addr) <= csm_pkg::PBI_LAST))
      else $error("pbi window wrong");
   nvm_hit_a: assert property (i_bus_valid && i_internal_nvm_enable |=> o_nvm_block ==
      $past(i_bus_addr[19:16]) && o_nvm_sel == ($past(i_bus_addr) <= csm_pkg::NVM_LAST))
      else $error("nvm decode wrong");
   vec_pick_a: assert property (s_release |=> o_reset_vector == ($past(i_vector_prefix_bit)
      ? csm_pkg::VEC_HIGH : csm_pkg::VEC_LOW))
      else $error("reset vector wrong");
   boot_stay_off_a: assert property (!o_boot_mode |=> !o_boot_mode)
      else $error("boot mode came back");
   nvm_ctrl_a: assert property (i_bus_valid && i_internal_nvm_enable |=> o_nvm_ctrl_sel ==
      ($past(i_bus_addr) >= csm_pkg::NVM_CTRL_BASE && $past(i_bus_addr) <=
      csm_pkg::NVM_CTRL_LAST))
      else $error("nvm control decode wrong");
endmodule // csm_decoder_chk
bind csm_decoder csm_decoder_chk chk_u (.i_clock, .i_rst, .i_vector_prefix_bit,
   .i_internal_nvm_enable, .i_bus_valid, .i_wr_en, .i_wr_option, .i_bus_addr, .i_wr_data,
   .o_reset_vector, .i_wr_region, .o_cs_n, .o_nvm_block, .o_boot_mode, .o_nvm_sel,
   .o_nvm_ctrl_sel, .o_pbi_sel);

// ==== test/tb.sv ====
`timescale 1ns/1ns
// Purpose: Self-checking bench for the decoder.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Option one is written so region one is not the whole space.
module tb;
   logic        clk = 0, rst = 1, strap = 0, nvm_en = 1, valid = 0, wr_en = 0, wr_opt = 0;
   logic [1:0]  wr_reg = 2'h0;
   logic [31:0] addr = 32'h0, wr_dat = 32'h0, vec;
   logic [3:0]  cs_n, blk, ack_n;
   logic        boot, nvm_s, ctl_s, pbi_s;
   int          n_fail = 0, check_count = 0, cyc = 0;
   always #50 clk = ~clk;
   csm_decoder dut_u (.i_clock(clk), .i_rst(rst), .i_vector_prefix_bit(strap),
      .i_internal_nvm_enable(nvm_en), .i_bus_valid(valid), .i_bus_addr(addr), .i_wr_en(wr_en),
      .i_wr_region(wr_reg), .i_wr_option(wr_opt), .i_wr_data(wr_dat), .o_cs_n(cs_n),
      .o_boot_mode(boot), .o_nvm_sel(nvm_s), .o_nvm_block(blk), .o_nvm_ctrl_sel(ctl_s),
      .o_pbi_sel(pbi_s), .o_reset_vector(vec));
   csm_bank_model bank_u (.i_clock(clk), .i_cs_n(cs_n), .o_ack_n(ack_n));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 400) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic s);
      rst = 1; strap = s; step(6); rst = 0; step();
   endtask
   task automatic wr(input logic [1:0] r, input logic o, input logic [31:0] d);
      wr_en = 1;
      wr_reg = r;
      wr_opt = o;
      wr_dat = d;
      step();
      // One edge with the strobe low, so back-to-back writes never re-raise it at once
      wr_en = 0;
      step();
   endtask
   task automatic acc(input logic [31:0] a);
      valid = 1;
      addr = a;
      step();
   endtask
   task automatic t_boot;
      do_reset(1'b0);
      chk(vec, csm_pkg::VEC_LOW);
      acc(32'h1234_5678);
      chk(32'(cs_n), 32'h0000_000E);
      wr(2'h0, 1'b0, 32'h0080_0003);
      chk(32'(boot), 32'h0000_0001);
      acc(32'hFFF0_0000);
      chk(32'(cs_n), 32'h0000_000E);
      $display("boot test done");
   endtask
   task automatic t_map;
      logic [31:0] ta [9] = '{32'h0080_0000, 32'h009F_FFFC, 32'h00A0_0000, 32'hFFF0_0100,
         32'hFFFF_FFFC, 32'h0200_7FFC, 32'h0100_0000, 32'h0100_8000, 32'h0030_0000};
      logic [3:0]  te [9] = '{4'hE, 4'hE, 4'hF, 4'hD, 4'hD, 4'hB, 4'h7, 4'hF, 4'hF};
      valid = 0;
      wr(2'h1, 1'b0, 32'hFFF0_0003);
      wr(2'h1, 1'b1, 32'hFFF0_0000);
      wr(2'h3, 1'b0, 32'h0100_0807);
      wr(2'h3, 1'b1, 32'hFFFF_80F0);
      wr(2'h2, 1'b0, 32'h0200_0001);
      wr(2'h2, 1'b1, 32'hFFFF_8000);
      wr(2'h0, 1'b1, 32'hFFE0_0030);
      chk(32'(boot), 32'h0000_0000);
      foreach (ta[i]) begin
         acc(ta[i]);
         chk(32'(cs_n), 32'(te[i]));
      end
      acc(32'h0100_0000);
      valid = 0;
      step();
      chk(32'(ack_n), 32'h0000_0007);
      $display("map test done");
   endtask
   task automatic t_int;
      acc(32'h0005_0000);
      chk(32'({nvm_s, blk}), 32'h0000_0015);
      acc(32'h002F_C000);
      chk(32'(ctl_s), 32'h0000_0001);
      acc(32'h0030_7FFF);
      chk(32'(pbi_s), 32'h0000_0001);
      acc(32'h0030_8000);
      chk(32'(pbi_s), 32'h0000_0000);
      nvm_en = 0;
      acc(32'h000F_FFFF);
      chk(32'({nvm_s, ctl_s}), 32'h0000_0000);
      acc(32'h002F_C000);
      chk(32'(ctl_s), 32'h0000_0000);
      valid = 0;
      nvm_en = 1;
      $display("internal test done");
   endtask
   task automatic t_vec;
      do_reset(1'b1);
      chk(vec, csm_pkg::VEC_HIGH);
      acc(32'h0100_0000);
      chk(32'(cs_n), 32'h0000_000E);
      valid = 0;
      $display("vector test done");
   endtask
   initial begin
      t_boot(); t_map(); t_int(); t_vec();
      print_verdict();
   end
endmodule // tb
